// ===== verilog/rjb_pdv_ctrl.sv
// Receive-side PDV control for one shared absorption structure.
// Assumes packet descriptors, TDM read pointer and bus timestamp share sys_clk.
module rjb_pdv_ctrl
    import rjb_pkg::*;
(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // Packets from disassembly
    input  wire logic                   pkt_valid,
    input  wire rjb_pkt_t               pkt,
    output logic                        pkt_ready,
    // Configuration
    input  wire rjb_cfg_t               cfg,
    // Software requests, one-cycle set pulses
    input  wire logic                   reset_offset_next_packet,
    input  wire logic                   reset_offset_on_marker,
    input  wire logic                   reset_offset_after_gap,
    input  wire logic                   clear_diag,
    // TDM read side
    input  wire logic [PTR_W-1:0]       rd_ptr,
    input  wire logic [TS_W-1:0]        bus_ts,
    // Write command
    output logic                        wr_valid,
    output rjb_wr_t                     wr,
    // Events, one-cycle pulses
    output rjb_ev_t                     ev,
    // Shared structure state
    output logic signed [TS_W-1:0]      slip_offset,
    output logic signed [TS_W-1:0]      min_delta,
    output logic signed [TS_W-1:0]      max_delta,
    output logic [TS_W-1:0]             last_bus_ts,
    output logic [2:0]                  req_pending,
    output logic                        init_done
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic {
        S_IDLE,
        S_EVAL
    } rjb_phase_t;

    typedef struct packed {
        rjb_phase_t              phase;
        rjb_pkt_t                pkt;
        logic [TS_W-1:0]         ts_cap;
        logic [PTR_W-1:0]        rd_cap;
        logic                    init_done;
        logic signed [TS_W-1:0]  off;
        logic signed [TS_W-1:0]  dmin;
        logic signed [TS_W-1:0]  dmax;
        logic [2:0]              req;
        logic [TS_W-1:0]         next_exp;
        logic                    have_exp;
        logic [TS_W-1:0]         last_bus_ts;
        logic                    wr_valid;
        rjb_wr_t                 wr;
        rjb_ev_t                 ev;
    } rjb_st_t;

    rjb_st_t st;
    rjb_st_t next_st;

    // ------------------------------------------------------------
    // Input buffering
    // ------------------------------------------------------------
    logic     q_valid;
    rjb_pkt_t q_pkt;
    logic     q_ready;

    rjb_fifo #(
        .W     ($bits(rjb_pkt_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (pkt_valid),
        .in_data   (pkt),
        .in_ready  (pkt_ready),
        .out_valid (q_valid),
        .out_data  (q_pkt),
        .out_ready (q_ready)
    );

    // Evaluation takes two cycles per packet, so the FIFO absorbs bursts
    assign q_ready = (st.phase == S_IDLE);

    logic gap_big;

    rjb_gap_detect u_gap (
        .remote_ts   (st.pkt.remote_ts),
        .expected_ts (st.next_exp),
        .gap_code    (cfg.gap_code),
        .gap_big     (gap_big)
    );

    // ------------------------------------------------------------
    // Evaluation arithmetic
    // ------------------------------------------------------------
    logic signed [TS_W-1:0] delta;
    logic signed [TS_W-1:0] desired;
    logic signed [TS_W-1:0] off_base;
    logic signed [TS_W-1:0] lead_nom;
    logic signed [TS_W-1:0] lead;
    logic signed [TS_W-1:0] nsamp_s;
    logic signed [TS_W-1:0] lead_floor;
    logic                   hit_rso;
    logic                   hit_rsm;
    logic                   hit_rsl;
    logic                   hit_any;
    logic                   under;
    logic                   over;

    always_comb begin
        desired = $signed(cfg.desired_delta);
        nsamp_s = $signed({{(TS_W-NSAMP_W){1'b0}}, st.pkt.nsamp});
        delta   = $signed(st.pkt.remote_ts - st.ts_cap);
        hit_rso = st.req[0];
        hit_rsm = st.req[1] && st.pkt.marker;
        hit_rsl = st.req[2] && st.have_exp && gap_big;
        hit_any = hit_rso || hit_rsm || hit_rsl;
        off_base = hit_any ? $signed(OFFSET_RESET) : st.off;
        lead_nom = delta - desired - off_base;
        // room for the longest expected payload
        lead_floor = $signed({{(TS_W-NSAMP_W){1'b0}}, cfg.max_payload}) - nsamp_s;
        under = (lead_nom < lead_floor);
        over  = (lead_nom + nsamp_s - 1) > $signed({{(TS_W-PTR_W){1'b0}}, cfg.max_used});
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st          = st;
        next_st.wr_valid = 1'b0;
        next_st.ev       = '0;
        lead             = lead_nom;
        case (st.phase)
            S_IDLE: begin
                if (q_valid) begin
                    next_st.pkt    = q_pkt;
                    next_st.ts_cap = bus_ts;
                    next_st.rd_cap = rd_ptr;
                    next_st.phase  = S_EVAL;
                end
            end
            S_EVAL: begin
                next_st.phase = S_IDLE;
                if (cfg.always_reset) begin
                    lead = delta - desired;
                end else if (!st.init_done) begin
                    lead = $signed({{(TS_W-PTR_W){1'b0}}, cfg.init_lead});
                    next_st.off = delta - desired - lead;
                    next_st.ev.first = 1'b1;
                end else if (under) begin
                    lead = $signed({{(TS_W-PTR_W){1'b0}}, cfg.underrun_lead});
                    next_st.ev.underrun = 1'b1;
                    next_st.off = cfg.freeze_offset_on_underrun ? off_base
                                                                : delta - desired - lead;
                end else if (over) begin
                    lead = $signed({{(TS_W-PTR_W){1'b0}}, cfg.overrun_lead});
                    next_st.ev.overrun = 1'b1;
                    next_st.off = cfg.freeze_offset_on_overrun ? off_base
                                                               : delta - desired - lead;
                end else begin
                    next_st.off = off_base;
                end
                next_st.init_done = 1'b1;
                // position from timestamp, wraps on buffer size
                next_st.wr.wr_ptr = st.rd_cap + lead[PTR_W-1:0];
                next_st.wr.chan   = st.pkt.chan;
                next_st.wr.nsamp  = st.pkt.nsamp;
                next_st.wr_valid  = 1'b1;
                next_st.ev.offset_reset = hit_any && !cfg.always_reset;
                if (!cfg.always_reset) begin
                    next_st.req = st.req & ~{hit_rsl, hit_rsm, hit_rso};
                end
                if (delta < st.dmin) begin
                    next_st.dmin = delta;
                end
                if (delta > st.dmax) begin
                    next_st.dmax = delta;
                end
                next_st.next_exp = st.pkt.remote_ts
                                 + {{(TS_W-NSAMP_W){1'b0}}, st.pkt.nsamp};
                next_st.have_exp = 1'b1;
                next_st.last_bus_ts = st.ts_cap;
            end
            default: begin
                next_st.phase = S_IDLE;
            end
        endcase
        if (clear_diag) begin
            next_st.dmin = $signed(MIN_RESET);
            next_st.dmax = $signed(MAX_RESET);
        end
        // New requests win over the hardware clear in the same cycle
        next_st.req = next_st.req | {reset_offset_after_gap,
                                     reset_offset_on_marker,
                                     reset_offset_next_packet};
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st       <= '0;
            st.phase <= S_IDLE;
            st.off   <= $signed(OFFSET_RESET);
            st.dmin  <= $signed(MIN_RESET);
            st.dmax  <= $signed(MAX_RESET);
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wr_valid    = st.wr_valid;
    assign wr          = st.wr;
    assign ev          = st.ev;
    assign slip_offset = st.off;
    assign min_delta   = st.dmin;
    assign max_delta   = st.dmax;
    assign last_bus_ts = st.last_bus_ts;
    assign req_pending = st.req;
    assign init_done   = st.init_done;
endmodule // rjb_pdv_ctrl

// ===== inc/rjb_pkg.sv
// Constants and carrier types shared by the jitter buffer PDV control.
// Assumes one receive clock; TDM read pointer and bus timestamp are on it.
//
// Overview of operation
// - Buffer position of each packet follows its remote RTP timestamp.
// - Sample-count changes up to max payload are absorbed, not seen as PDV.
// - PDV window equals max used samples; hardware adds payload size minus one.
// - Lead below max payload minus sample count declares underrun; pointer goes to read pointer plus underrun lead.
// - Lead above max used declares overrun; pointer goes to read pointer plus overrun lead.
// - First packet on the structure uses the initial lead.
// - Every slip updates the accumulated slip offset unless its freeze bit is set.
// - Samples emerge at the desired remote-local delta plus the slip offset.
// - Running minimum of remote-minus-local delta is kept.
// - Running maximum of remote-minus-local delta is kept.
// - One-shot request clears offset and slips on the next packet.
// - Marker request clears offset on the next packet with marker set.
// - Loss request clears offset on first packet after a long enough gap.
// - Always-reset writes at exactly desired delta and never alters offset.
// - Overrun freeze keeps offset unchanged; only an event is reported.
// - Underrun freeze keeps offset unchanged; only an event is reported.
// - Bus timestamp at processing time is stored for every packet.
// - Many channels share one structure; any slip applies to all.
// - Offset counts overruns positive and underruns negative.
// - Gap code 0 to 7 maps to 16 up to 2048 frames.
// - Request bits clear themselves once the delta has been applied.
// - Delta is remote timestamp minus local bus timestamp.
package rjb_pkg;

    localparam int PTR_W    = 12;
    localparam int TS_W     = 32;
    localparam int NSAMP_W  = 11;
    localparam int CHAN_W   = 10;
    localparam int GAP_W    = 3;
    localparam int FIFO_DEPTH = 8;

    // Silence threshold for code 000, doubled per code step
    localparam logic [TS_W-1:0] GAP_BASE_FRAMES = 32'h0000_0010;

    // Values after reset
    localparam logic [TS_W-1:0] OFFSET_RESET = 32'h0000_0000;
    localparam logic [TS_W-1:0] MIN_RESET    = 32'h7FFF_FFFF;
    localparam logic [TS_W-1:0] MAX_RESET    = 32'h8000_0000;

    typedef struct packed {
        logic [CHAN_W-1:0]  chan;
        logic [TS_W-1:0]    remote_ts;
        logic [NSAMP_W-1:0] nsamp;
        logic               marker;
    } rjb_pkt_t;

    typedef struct packed {
        logic [TS_W-1:0]    desired_delta;
        logic [PTR_W-1:0]   max_used;
        logic [NSAMP_W-1:0] max_payload;
        logic [PTR_W-1:0]   underrun_lead;
        logic [PTR_W-1:0]   overrun_lead;
        logic [PTR_W-1:0]   init_lead;
        logic               freeze_offset_on_overrun;
        logic               freeze_offset_on_underrun;
        logic               always_reset;
        logic [GAP_W-1:0]   gap_code;
    } rjb_cfg_t;

    typedef struct packed {
        logic [CHAN_W-1:0]  chan;
        logic [PTR_W-1:0]   wr_ptr;
        logic [NSAMP_W-1:0] nsamp;
    } rjb_wr_t;

    typedef struct packed {
        logic underrun;
        logic overrun;
        logic first;
        logic offset_reset;
    } rjb_ev_t;

endpackage

// ===== verilog/rjb_fifo.sv
// Packet descriptor FIFO in front of the PDV evaluation.
// Assumes single clock; in_ready is registered, so writers see it one cycle late-safe.
module rjb_fifo
    import rjb_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // Drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          rdy;
    } rjb_fifo_st_t;

    rjb_fifo_st_t st;
    rjb_fifo_st_t next_st;
    logic [W-1:0] mem [DEPTH];
    logic         push;
    logic         pop;

    assign push      = in_valid && st.rdy;
    assign pop       = out_valid && out_ready;
    assign out_valid = (st.cnt != '0);
    assign out_data  = mem[st.rp];
    assign in_ready  = st.rdy;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_st.rdy = (next_st.cnt < (AW+1)'(DEPTH));
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st     <= '0;
            st.rdy <= 1'b1;
        end else begin
            st <= next_st;
        end
        if (push) begin
            mem[st.wp] <= in_data;
        end
    end
endmodule // rjb_fifo

// ===== verilog/rjb_gap_detect.sv
// Silence gap detector: compares timestamp jump with a power-of-two threshold.
// Purely combinational; caller qualifies the result with a valid expectation.
module rjb_gap_detect
    import rjb_pkg::*;
(
    // Timestamps
    input  wire logic [TS_W-1:0]  remote_ts,
    input  wire logic [TS_W-1:0]  expected_ts,
    // Threshold code
    input  wire logic [GAP_W-1:0] gap_code,
    // Result
    output logic                  gap_big
);
    logic signed [TS_W-1:0] lost;
    logic        [TS_W-1:0] thr;

    assign thr  = GAP_BASE_FRAMES << gap_code;
    assign lost = $signed(remote_ts - expected_ts);
    assign gap_big = (lost > 0) && ($unsigned(lost) >= thr);
endmodule // rjb_gap_detect

// ===== test/rjb_pdv_checker.sv
// Concurrent checks on the PDV control top ports.
// Assumes one sys_clk domain and the port names of rjb_pdv_ctrl.
module rjb_pdv_checker
    import rjb_pkg::*;
(
    // Clock and reset
    input wire logic                   sys_clk,
    input wire logic                   rst_n,
    // Stimulus side
    input wire logic                   pkt_valid,
    input wire logic                   pkt_ready,
    input wire rjb_cfg_t               cfg,
    input wire logic                   reset_offset_next_packet,
    input wire logic [PTR_W-1:0]       rd_ptr,
    input wire logic [TS_W-1:0]        bus_ts,
    // Results
    input wire logic                   wr_valid,
    input wire rjb_wr_t                wr,
    input wire rjb_ev_t                ev,
    input wire logic signed [TS_W-1:0] slip_offset,
    input wire logic signed [TS_W-1:0] min_delta,
    input wire logic signed [TS_W-1:0] max_delta,
    input wire logic [TS_W-1:0]        last_bus_ts,
    input wire logic [2:0]             req_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dck @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ----------------
    // Sequences
    // ----------------
    sequence s_take; pkt_valid && pkt_ready; endsequence
    sequence s_over; wr_valid && ev.overrun && !ev.first; endsequence
    sequence s_under; wr_valid && ev.underrun && !ev.first; endsequence
    // Capture of rd_ptr and bus_ts happens two edges before the write command
    chk_take_answer: assert property (s_take |-> ##[3:30] wr_valid)
        else $error("accepted packet produced no write");
    chk_wr_single: assert property (wr_valid |=> !wr_valid)
        else $error("write command wider than one cycle");
    chk_ev_with_wr: assert property (ev != '0 |-> wr_valid)
        else $error("event without write command");
    chk_first_lead: assert property (wr_valid && ev.first |->
        wr.wr_ptr == PTR_W'($past(rd_ptr, 2) + cfg.init_lead))
        else $error("first packet not placed at init lead");
    chk_under_lead: assert property (s_under |->
        wr.wr_ptr == PTR_W'($past(rd_ptr, 2) + cfg.underrun_lead))
        else $error("underrun not placed at underrun lead");
    chk_over_lead: assert property (s_over |->
        wr.wr_ptr == PTR_W'($past(rd_ptr, 2) + cfg.overrun_lead))
        else $error("overrun not placed at overrun lead");
    // Mode bits are read on the evaluation edge, one edge before the write shows
    chk_over_frozen: assert property (s_over ##0 ($past(cfg.freeze_offset_on_overrun)
        && !ev.offset_reset) |-> slip_offset == $past(slip_offset))
        else $error("offset moved on frozen overrun");
    chk_under_frozen: assert property (s_under ##0 ($past(cfg.freeze_offset_on_underrun)
        && !ev.offset_reset) |-> slip_offset == $past(slip_offset))
        else $error("offset moved on frozen underrun");
    chk_always_keep: assert property (wr_valid && $past(cfg.always_reset) |->
        ev == '0 && $stable(slip_offset))
        else $error("always mode slipped");
    chk_bus_stamp: assert property (wr_valid |-> last_bus_ts == $past(bus_ts, 2))
        else $error("stored bus stamp wrong");
    chk_min_max: assert property (wr_valid |-> min_delta <= max_delta)
        else $error("minimum above maximum");
    chk_req_set: assert property (reset_offset_next_packet |=> req_pending[0])
        else $error("request not held");
endmodule // rjb_pdv_checker

bind rjb_pdv_ctrl rjb_pdv_checker u_chk (.sys_clk, .rst_n, .pkt_valid, .pkt_ready, .cfg,
    .reset_offset_next_packet, .rd_ptr, .bus_ts, .wr_valid, .wr, .ev, .slip_offset,
    .min_delta, .max_delta, .last_bus_ts, .req_pending);

// ===== test/rjb_tdm_model.sv
// TDM read side: read pointer and bus timestamp, one frame per clock while running.
// Assumes the bench loads a known position, or holds run low, before each packet it judges.
module rjb_tdm_model
    import rjb_pkg::*;
(
    // Clock
    input  wire logic             sys_clk,
    // Control from the bench
    input  wire logic             run,
    input  wire logic             load,
    input  wire logic [PTR_W-1:0] ld_ptr,
    input  wire logic [TS_W-1:0]  ld_ts,
    // Toward the block
    output logic [PTR_W-1:0]      rd_ptr,
    output logic [TS_W-1:0]       bus_ts
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pointer wraps at the buffer size through its own width
    always @(posedge sys_clk) begin
        if (load) begin
            rd_ptr <= ld_ptr;
            bus_ts <= ld_ts;
        end else if (run) begin
            rd_ptr <= rd_ptr + 1'b1;
            bus_ts <= bus_ts + 1'b1;
        end
    end
endmodule // rjb_tdm_model

// ===== test/tb_rjb_pdv_ctrl.sv
// Self-checking bench for the PDV control: slips, requests, diagnostics, FIFO.
// Assumes the TDM model and the bound checker are compiled alongside.
module tb_rjb_pdv_ctrl
    import rjb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   sys_clk, rst_n, pkt_valid, pkt_ready, wr_valid, init_done;
    logic                   clear_diag, rq_next, rq_mark, rq_gap, run, load;
    rjb_pkt_t               pkt;
    rjb_cfg_t               cfg;
    rjb_wr_t                wr;
    rjb_ev_t                ev;
    logic [PTR_W-1:0]       rd_ptr, ld_ptr;
    logic [TS_W-1:0]        bus_ts, ld_ts, last_bus_ts, ts, off;
    logic signed [TS_W-1:0] slip_offset, min_delta, max_delta;
    logic [2:0]             req_pending;
    int                     errors, n_compared;

    rjb_pdv_ctrl dut (.sys_clk, .rst_n, .pkt_valid, .pkt, .pkt_ready, .cfg,
        .reset_offset_next_packet(rq_next), .reset_offset_on_marker(rq_mark),
        .reset_offset_after_gap(rq_gap), .clear_diag, .rd_ptr, .bus_ts, .wr_valid, .wr,
        .ev, .slip_offset, .min_delta, .max_delta, .last_bus_ts, .req_pending, .init_done);
    rjb_tdm_model tdm_side (.sys_clk, .run, .load, .ld_ptr, .ld_ts, .rd_ptr, .bus_ts);

    // ----------------
    // Helpers
    // ----------------
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tdm(logic [PTR_W-1:0] p, logic [TS_W-1:0] t);
        load = 1;
        ld_ptr = p;
        ld_ts = t;
        step();
        load = 0;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        step();
        s = 0;
        step();
    endtask
    // Offers one descriptor, then waits for its write command
    task automatic send(logic [TS_W-1:0] t, logic mk);
        int n;
        n = 0;
        pkt = '{chan: 10'h005, remote_ts: t, nsamp: 11'h008, marker: mk};
        pkt_valid = 1;
        while (pkt_ready !== 1'b1 && n < 40) begin
            step();
            n++;
        end
        check("offer taken", pkt_ready, 1'b1);
        step();
        pkt_valid = 0;
        n = 0;
        do begin
            step();
            n++;
        end while (wr_valid !== 1'b1 && n < 40);
        check("write seen", wr_valid, 1'b1);
    endtask
    task automatic expect_wr(string s, logic [PTR_W-1:0] p, logic [3:0] e, logic [31:0] o);
        check({s, " ptr"}, wr.wr_ptr, p);
        check({s, " ev"}, ev, e);
        check({s, " offset"}, slip_offset, o);
        check({s, " chan"}, wr.chan, 10'h005);
        check({s, " nsamp"}, wr.nsamp, 11'h008);
    endtask
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_first();
        step();
        check("offset at reset", slip_offset, 32'h0);
        tdm(12'h064, 32'h3E8);
        send(32'h41A, 1'b0);
        expect_wr("first", 12'h06E, 4'h2, 32'h28);
        check("first min", min_delta, 32'h32);
        check("first max", max_delta, 32'h32);
        check("bus stamp", last_bus_ts, 32'h3E8);
        check("init done", init_done, 1'b1);
    endtask
    task automatic t_slips();
        send(32'h422, 1'b0);
        expect_wr("inside", 12'h076, 4'h0, 32'h28);
        check("max", max_delta, 32'h3A);
        send(32'h410, 1'b0);
        expect_wr("under", 12'h078, 4'h8, 32'h14);
        check("min", min_delta, 32'h28);
        send(32'h514, 1'b0);
        expect_wr("over", 12'h0FA, 4'h4, 32'h96);
    endtask
    task automatic t_freeze();
        cfg.freeze_offset_on_overrun = 1;
        send(32'h5DC, 1'b0);
        expect_wr("frozen over", 12'h0FA, 4'h4, 32'h96);
        cfg.freeze_offset_on_overrun = 0;
        cfg.freeze_offset_on_underrun = 1;
        send(32'h44C, 1'b0);
        expect_wr("frozen under", 12'h078, 4'h8, 32'h96);
        cfg.freeze_offset_on_underrun = 0;
    endtask
    task automatic t_marker();
        pulse(rq_mark);
        check("marker pending", req_pending, 3'h2);
        send(32'h49C, 1'b0);
        expect_wr("no marker", 12'h082, 4'h0, 32'h96);
        send(32'h406, 1'b1);
        expect_wr("marker", 12'h082, 4'h1, 32'h0);
        check("marker done", req_pending, 3'h0);
    endtask
    task automatic t_gap();
        ts = 32'h578;
        send(ts, 1'b0);
        expect_wr("preset", 12'h0FA, 4'h4, 32'hFA);
        off = 32'hFA;
        for (int k = 0; k < 8; k++) begin
            cfg.gap_code = k[2:0];
            pulse(rq_gap);
            ts = ts + 32'h7 + (32'h10 << k);
            tdm(12'h064, ts - 32'h1E - off);
            send(ts, 1'b0);
            expect_wr("short gap", 12'h082, 4'h0, off);
            ts = ts + 32'h8 + (32'h10 << k);
            tdm(12'h064, ts - 32'h1E);
            send(ts, 1'b0);
            expect_wr("long gap", 12'h082, 4'h1, 32'h0);
            off = 32'h0;
        end
    endtask
    task automatic t_next_always();
        pulse(rq_next);
        check("next pending", req_pending, 3'h1);
        ts = ts + 32'h8;
        tdm(12'hFFA, ts - 32'h1E);
        send(ts, 1'b0);
        expect_wr("next wrap", 12'h018, 4'h1, 32'h0);
        check("next done", req_pending, 3'h0);
        ts = ts + 32'h8;
        tdm(12'h064, ts - 32'h190);
        send(ts, 1'b0);
        expect_wr("reslip", 12'h0FA, 4'h4, 32'hFA);
        cfg.always_reset = 1;
        pulse(rq_next);
        ts = ts + 32'h8;
        tdm(12'h064, ts);
        send(ts, 1'b0);
        expect_wr("always", 12'h064, 4'h0, 32'hFA);
        check("always keeps request", req_pending, 3'h1);
    endtask
    // Leaving always mode: the pending one-shot request now takes effect
    task automatic t_rebase();
        cfg.always_reset = 0;
        cfg.desired_delta = cfg.desired_delta + slip_offset;
        pulse(rq_next);
        ts = ts + 32'h8;
        tdm(12'h064, ts - 32'h118);
        send(ts, 1'b0);
        expect_wr("rebase", 12'h082, 4'h1, 32'h0);
        cfg.always_reset = 1;
    endtask
    // Back-to-back offers outrun the two-cycle drain, so the FIFO must refuse
    task automatic t_fifo();
        int taken, wrs, full;
        taken = 0;
        wrs = 0;
        full = 0;
        run = 1;
        pkt_valid = 1;
        for (int i = 0; i < 24; i++) begin
            if (pkt_ready === 1'b1) taken++;
            else full++;
            step();
            if (wr_valid === 1'b1) wrs++;
        end
        pkt_valid = 0;
        repeat (40) begin
            step();
            if (wr_valid === 1'b1) wrs++;
        end
        run = 0;
        check("refused", full > 0, 1'b1);
        check("pairs", wrs, taken);
        check("drained", pkt_ready, 1'b1);
        pulse(clear_diag);
        check("min cleared", min_delta, 32'h7FFF_FFFF);
        check("max cleared", max_delta, 32'h8000_0000);
    endtask

    initial begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #100us;
        errors++;
        summarize();
    end
    initial begin
        {rst_n, pkt_valid, clear_diag, rq_next, rq_mark, rq_gap, run, load} = '0;
        pkt = '0;
        ld_ptr = '0;
        ld_ts = '0;
        cfg = '0;
        cfg.desired_delta = 32'h0;
        cfg.max_used = 12'h0C8;
        cfg.max_payload = 11'h010;
        cfg.underrun_lead = 12'h014;
        cfg.overrun_lead = 12'h096;
        cfg.init_lead = 12'h00A;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1;
        t_first();
        t_slips();
        t_freeze();
        t_marker();
        t_gap();
        t_next_always();
        t_rebase();
        t_fifo();
        summarize();
    end
endmodule // tb_rjb_pdv_ctrl
